// ==== rtl/hbd_pkg.sv ====
// package for the hdlc buffer-descriptor engine: descriptor layout, register map, states
// assumes a 32-bit word memory port and a plain register port on the same clock
package hbd_pkg;

	// transmit descriptor status bits
	localparam int TXD_READY_BIT = 0;
	localparam int TXD_WRAP_BIT = 2;
	localparam int TXD_INT_BIT = 3;
	localparam int TXD_LAST_BIT = 4;
	localparam int TXD_CRC_BIT = 5;
	localparam int TXD_LEN_LSB = 16;

	// receive descriptor status bits
	localparam int RXD_EMPTY_BIT = 0;
	localparam int RXD_LAST_BIT = 4;
	localparam int RXD_NONOCT_BIT = 11;
	localparam int RXD_LEN_LSB = 16;

	// descriptor size in bytes (status word plus pointer word)
	localparam logic [31:0] BD_BYTES = 32'h0000_0008;
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

	// register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TX_BASE = 8'h04;
	localparam logic [7:0] REG_RX_BASE = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_EVENT_ADDR = 8'h10;
	localparam logic [7:0] REG_TX_PTR = 8'h14;

	// control register fields
	localparam int CTRL_TX_EN_BIT = 0;
	localparam int CTRL_RX_EN_BIT = 1;
	localparam int CTRL_HDLC_BIT = 2;

	// reset values
	localparam logic [31:0] RST_BASE = 32'h0000_0000;
	localparam logic [2:0] RST_CTRL = 3'h0;

	// event entry bits written to the interrupt table, one word further on per event
	localparam logic [31:0] EVT_TX_BUFFER = 32'h0000_0001;
	localparam logic [31:0] EVT_VALID = 32'h8000_0000;

	// poll wait when a descriptor is not ready
	localparam int POLL_NS = 400;
	localparam int CLK_NS = 40;
	localparam int POLL_CYCLES = (POLL_NS + CLK_NS - 1) / CLK_NS;

	// memory request
	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} hbd_mem_req_t;

	// serial-side transmit byte
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic last;
		logic append_crc_flag;
	} hbd_tx_byte_t;

	// receive frame end report from the serial side
	typedef struct packed {
		logic valid;
		logic [15:0] octets;
		logic [2:0] loose_bits;
		logic [7:0] loose_data;
	} hbd_rx_end_t;

	typedef enum logic [8:0] {
		TX_IDLE = 9'h001,
		TX_RD_STAT = 9'h002,
		TX_RD_PTR = 9'h004,
		TX_RD_DATA = 9'h008,
		TX_SEND = 9'h010,
		TX_WB = 9'h020,
		TX_EVT = 9'h040,
		TX_WAIT = 9'h080,
		TX_NEXT = 9'h100
	} hbd_tx_state_t;

endpackage

// ==== rtl/hbd_rx_tail.sv ====
// hbd_rx_tail: builds the closing words of a received frame
// assumes frame octet count and residual bits arrive together from the serial receiver
`timescale 1ns/1ps
module hbd_rx_tail import hbd_pkg::*; (
	// frame end
	input wire logic [15:0] octets,
	input wire logic [2:0] loose_bits,
	input wire logic [7:0] loose_data,
	// results
	output logic [15:0] stored_byte_count,
	output logic nonoct,
	output logic [31:0] tail_word,
	output logic [15:0] tail_offset
);
	logic [7:0] tail_byte;
	logic [7:0] mark;

	always_comb begin
		nonoct = (loose_bits != 3'h0);
		stored_byte_count = octets + {15'h0000, nonoct};
		mark = 8'h80 >> loose_bits;
		tail_byte = (loose_data & ~((8'hff >> loose_bits))) | mark;
		tail_word = {tail_byte, 24'h000000};
		// first long-word boundary at or after the whole octets; an aligned count is kept as the offset
		tail_offset = {octets[15:2] + 14'h0001, 2'b00};
		if (octets[1:0] == 2'b00 && octets != 16'h0000) begin
			tail_offset = octets;
		end
		if (octets == 16'h0000) begin
			tail_offset = 16'h0000;
		end
	end
endmodule

// ==== rtl/hbd_engine.sv ====
// hbd_engine: transmit descriptor walker and receive frame closer for one hdlc channel
// assumes a single-word memory port with read data valid in the grant cycle and a host sharing descriptors
// Notes on behaviour
// - a frame with extra bits counts one additional byte in its length
// - residual byte holds bits from msb, then a single one, then zeros
// - residual word lands on the long word following the frame data
// - flag, bit, flag reports length one, byte at offset zero
// - ready is cleared after transmission or on an error
// - only ready descriptors are owned and transmitted
// - after a wrap descriptor continue at the table base
// - table length set only by the wrap entry
// - interrupt bit posts a transmit buffer event after service
// - last bit ends the frame; otherwise frame continues
// - crc control counts only in hdlc mode on a last descriptor
// - crc control set sends crc; clear sends closing flag directly
// - any non-octet frame sets the non-octet error flag
// - last receive descriptor length is the total frame octets with crc
`timescale 1ns/1ps
module hbd_engine import hbd_pkg::*; #(
	parameter int POLL = POLL_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// shared memory
	output hbd_mem_req_t mem,
	input wire logic mem_gnt,
	input wire logic [31:0] mem_rdata,
	// transmit byte stream
	output hbd_tx_byte_t tx_out,
	input wire logic tx_take,
	input wire logic tx_error,
	// receive frame end
	input hbd_rx_end_t rx_end,
	output logic rx_end_ready
);
	typedef struct packed {
		hbd_tx_state_t st;
		logic [2:0] ctrl;
		logic [31:0] tx_table_base;
		logic [31:0] rx_base;
		logic [31:0] evt_addr;
		logic [31:0] bd_addr;
		logic [31:0] stat;
		logic [31:0] buf_ptr;
		logic [15:0] left;
		logic [1:0] lane;
		logic [31:0] word;
		logic err;
		logic [15:0] poll;
		hbd_mem_req_t mem;
		hbd_tx_byte_t tx_buffer_event;
		logic [31:0] rdata;
		logic [1:0] rx_step;
		logic [31:0] rx_bd;
		logic [31:0] rx_stat;
		logic [31:0] rx_ptr;
	} hbd_state_t;

	hbd_state_t cur_ff;
	hbd_state_t nxt_s;

	logic [15:0] rx_count;
	logic rx_nonoct;
	logic [31:0] rx_tail_word;
	logic [15:0] rx_tail_off;
	logic wrap;
	logic last;

	hbd_rx_tail u_tail (
		.octets(rx_end.octets),
		.loose_bits(rx_end.loose_bits),
		.loose_data(rx_end.loose_data),
		.stored_byte_count(rx_count),
		.nonoct(rx_nonoct),
		.tail_word(rx_tail_word),
		.tail_offset(rx_tail_off)
	);

	assign wrap = cur_ff.stat[TXD_WRAP_BIT];
	assign last = cur_ff.stat[TXD_LAST_BIT];
	assign mem = cur_ff.mem;
	assign tx_out = cur_ff.tx_buffer_event;
	assign reg_rdata = cur_ff.rdata;
	// receive closing borrows the memory port only while the walker cannot issue:
	// parked with transmit off, or still counting down a poll wait
	assign rx_end_ready = (cur_ff.rx_step == 2'h0) && !cur_ff.mem.req
		&& ((cur_ff.st == TX_IDLE && !cur_ff.ctrl[CTRL_TX_EN_BIT])
		|| (cur_ff.st == TX_WAIT && cur_ff.poll != 16'h0000));

	always_comb begin
		nxt_s = cur_ff;
		nxt_s.rdata = 32'h0000_0000;
		if (tx_take) begin
			nxt_s.tx_buffer_event.valid = 1'b0;
		end
		// a granted request drops unless a state below issues the next one
		if (mem_gnt) begin
			nxt_s.mem.req = 1'b0;
		end
		if (tx_error) begin
			nxt_s.err = 1'b1;
		end

		// register port
		if (reg_wr) begin
			unique case (reg_addr)
				REG_CTRL: nxt_s.ctrl = reg_wdata[2:0];
				REG_TX_BASE: nxt_s.tx_table_base = {reg_wdata[31:2], 2'b00};
				REG_RX_BASE: nxt_s.rx_base = {reg_wdata[31:2], 2'b00};
				REG_EVENT_ADDR: nxt_s.evt_addr = {reg_wdata[31:2], 2'b00};
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL: nxt_s.rdata = {29'h0, cur_ff.ctrl};
				REG_TX_BASE: nxt_s.rdata = cur_ff.tx_table_base;
				REG_RX_BASE: nxt_s.rdata = cur_ff.rx_base;
				REG_STATUS: nxt_s.rdata = {23'h0, cur_ff.st};
				REG_EVENT_ADDR: nxt_s.rdata = cur_ff.evt_addr;
				REG_TX_PTR: nxt_s.rdata = cur_ff.bd_addr;
				default: nxt_s.rdata = 32'h0000_0000;
			endcase
		end

		// transmit walker
		unique case (cur_ff.st)
			TX_IDLE: begin
				// wait for a receive close to release the memory port
				if (cur_ff.ctrl[CTRL_TX_EN_BIT] && cur_ff.rx_step == 2'h0) begin
					nxt_s.bd_addr = cur_ff.tx_table_base;
					nxt_s.st = TX_RD_STAT;
					nxt_s.mem = '{req: 1'b1, we: 1'b0, addr: cur_ff.tx_table_base,
						wdata: 32'h0};
				end
			end
			TX_RD_STAT: begin
				if (mem_gnt) begin
					nxt_s.stat = mem_rdata;
					if (mem_rdata[TXD_READY_BIT]) begin
						nxt_s.left = mem_rdata[31:TXD_LEN_LSB];
						// an abort in the same cycle as a new descriptor still counts
						nxt_s.err = tx_error;
						nxt_s.st = TX_RD_PTR;
						nxt_s.mem = '{req: 1'b1, we: 1'b0, addr: cur_ff.bd_addr + WORD_BYTES,
							wdata: 32'h0};
					end else begin
						nxt_s.poll = POLL[15:0];
						nxt_s.st = TX_WAIT;
					end
				end
			end
			TX_RD_PTR: begin
				if (mem_gnt) begin
					nxt_s.buf_ptr = mem_rdata;
					nxt_s.lane = mem_rdata[1:0];
					nxt_s.st = TX_RD_DATA;
					nxt_s.mem = '{req: 1'b1, we: 1'b0, addr: {mem_rdata[31:2], 2'b00},
						wdata: 32'h0};
				end
			end
			TX_RD_DATA: begin
				if (mem_gnt) begin
					nxt_s.word = mem_rdata;
					nxt_s.st = TX_SEND;
				end
			end
			TX_SEND: begin
				// abort or end of buffer: hand the descriptor back to software
				if (cur_ff.err || cur_ff.left == 16'h0000) begin
					nxt_s.st = TX_WB;
					nxt_s.stat[TXD_READY_BIT] = 1'b0;
					nxt_s.mem = '{req: 1'b1, we: 1'b1, addr: cur_ff.bd_addr,
						wdata: {cur_ff.stat[31:1], 1'b0}};
				end else if (!cur_ff.tx_buffer_event.valid || tx_take) begin
					nxt_s.tx_buffer_event.valid = 1'b1;
					nxt_s.tx_buffer_event.data = cur_ff.word[8 * (3 - cur_ff.lane) +: 8];
					// frame ends only on the last byte of a last descriptor
					nxt_s.tx_buffer_event.last = last && cur_ff.left == 16'h0001;
					// crc choice travels only on the final byte of the frame
					nxt_s.tx_buffer_event.append_crc_flag = last && cur_ff.left == 16'h0001
						&& cur_ff.ctrl[CTRL_HDLC_BIT] && cur_ff.stat[TXD_CRC_BIT];
					nxt_s.left = cur_ff.left - 16'h0001;
					nxt_s.lane = cur_ff.lane + 2'h1;
					if (cur_ff.lane == 2'h3 && cur_ff.left != 16'h0001) begin
						nxt_s.buf_ptr = {cur_ff.buf_ptr[31:2], 2'b00} + WORD_BYTES;
						nxt_s.st = TX_RD_DATA;
						nxt_s.mem = '{req: 1'b1, we: 1'b0,
							addr: {cur_ff.buf_ptr[31:2], 2'b00} + WORD_BYTES, wdata: 32'h0};
					end
				end
			end
			TX_WB: begin
				if (mem_gnt) begin
					if (cur_ff.stat[TXD_INT_BIT]) begin
						nxt_s.st = TX_EVT;
						nxt_s.mem = '{req: 1'b1, we: 1'b1, addr: cur_ff.evt_addr,
							wdata: EVT_VALID | EVT_TX_BUFFER};
					end else begin
						nxt_s.st = TX_NEXT;
					end
				end
			end
			TX_EVT: begin
				if (mem_gnt) begin
					nxt_s.evt_addr = cur_ff.evt_addr + WORD_BYTES;
					nxt_s.st = TX_NEXT;
				end
			end
			TX_WAIT: begin
				if (cur_ff.poll != 16'h0000) begin
					nxt_s.poll = cur_ff.poll - 16'h0001;
				end else if (cur_ff.rx_step == 2'h0) begin
					nxt_s.st = TX_RD_STAT;
					nxt_s.mem = '{req: 1'b1, we: 1'b0, addr: cur_ff.bd_addr, wdata: 32'h0};
				end
			end
			TX_NEXT: begin
				// no table size: only the wrap entry closes the ring
				nxt_s.bd_addr = wrap ? cur_ff.tx_table_base
					: cur_ff.bd_addr + BD_BYTES;
				nxt_s.mem = '{req: 1'b1, we: 1'b0,
					addr: wrap ? cur_ff.tx_table_base : cur_ff.bd_addr + BD_BYTES,
					wdata: 32'h0};
				nxt_s.st = TX_RD_STAT;
			end
			default: nxt_s.st = TX_IDLE;
		endcase
		if (!cur_ff.ctrl[CTRL_TX_EN_BIT] && (cur_ff.st == TX_WAIT)) begin
			nxt_s.st = TX_IDLE;
		end

		// receive frame closing: tail word for a non-octet frame only, then descriptor status
		unique case (cur_ff.rx_step)
			2'h0: begin
				if (rx_end.valid && rx_end_ready) begin
					nxt_s.rx_stat = {rx_count, 4'h0, rx_nonoct, 6'h00,
						1'b1, 4'h0};
					nxt_s.rx_stat[RXD_LAST_BIT] = 1'b1;
					nxt_s.rx_stat[RXD_EMPTY_BIT] = 1'b0;
					nxt_s.rx_bd = cur_ff.rx_base;
					if (rx_nonoct) begin
						nxt_s.rx_step = 2'h1;
						nxt_s.mem = '{req: 1'b1, we: 1'b0,
							addr: cur_ff.rx_base + WORD_BYTES, wdata: 32'h0};
					end else begin
						nxt_s.rx_step = 2'h3;
						nxt_s.mem = '{req: 1'b1, we: 1'b1, addr: cur_ff.rx_base,
							wdata: {rx_count, 4'h0, 1'b0, 6'h00, 1'b1, 4'h0}};
					end
					nxt_s.rx_ptr = {16'h0000, rx_tail_off};
					nxt_s.word = rx_tail_word;
				end
			end
			2'h1: begin
				if (mem_gnt) begin
					// pointer word just read; the tail lands past the frame data
					nxt_s.rx_step = 2'h2;
					nxt_s.mem = '{req: 1'b1, we: 1'b1,
						addr: {mem_rdata[31:2], 2'b00} + cur_ff.rx_ptr,
						wdata: cur_ff.word};
				end
			end
			2'h2: begin
				if (mem_gnt) begin
					nxt_s.rx_step = 2'h3;
					nxt_s.mem = '{req: 1'b1, we: 1'b1, addr: cur_ff.rx_bd,
						wdata: cur_ff.rx_stat};
				end
			end
			2'h3: begin
				if (mem_gnt) begin
					nxt_s.rx_step = 2'h0;
				end
			end
			default: nxt_s.rx_step = 2'h0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cur_ff <= '0;
			cur_ff.st <= TX_IDLE;
			cur_ff.ctrl <= RST_CTRL;
			cur_ff.tx_table_base <= RST_BASE;
			cur_ff.rx_base <= RST_BASE;
			cur_ff.evt_addr <= RST_BASE;
		end else begin
			cur_ff <= nxt_s;
		end
	end
endmodule

// ==== testbench/hbd_engine_props.sv ====
// checker for the hbd_engine ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module hbd_engine_props import hbd_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// memory and stream
	input hbd_mem_req_t mem,
	input wire logic mem_gnt,
	input hbd_tx_byte_t tx_out,
	input wire logic tx_take
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_reset_quiet: assert property ($fell(rst) |-> !mem.req && !tx_out.valid && reg_rdata == 32'h0)
		else $error("outputs active after reset");
	a_req_stable: assert property (mem.req && !mem_gnt |=> mem.req && $stable(mem))
		else $error("memory request changed before grant");
	a_req_drops: assert property (mem_gnt |=> !$stable(mem))
		else $error("memory request kept after grant");
	a_word_aligned: assert property (mem.req |-> mem.addr[1:0] == 2'h0)
		else $error("memory address not word aligned");
	a_tx_hold: assert property (tx_out.valid && !tx_take |=> $stable(tx_out))
		else $error("transmit byte changed before take");
	a_crc_last: assert property (tx_out.valid && tx_out.append_crc_flag |-> tx_out.last)
		else $error("crc request on a byte that is not last");
	a_last_gap: assert property (tx_out.valid && tx_take && tx_out.last |=> !tx_out.valid)
		else $error("byte follows frame end at once");
	a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h14 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_state_onehot: assert property (reg_rd && reg_addr == REG_STATUS |=> $onehot(reg_rdata))
		else $error("state code not one-hot");
endmodule
bind hbd_engine hbd_engine_props u_hbd_engine_props (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem(mem), .mem_gnt(mem_gnt), .tx_out(tx_out),
	.tx_take(tx_take));

// ==== testbench/hbd_mem_model.sv ====
// shared memory model: word store with a prompt or slow grant
// assumes the engine holds each request until granted
`timescale 1ns/1ps
module hbd_mem_model import hbd_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// pace
	input wire logic slow,
	// memory port
	input hbd_mem_req_t mem,
	output logic mem_gnt,
	output logic [31:0] mem_rdata
);
	logic [31:0] ram [0:511];
	logic [1:0] wait_ff;
	initial foreach (ram[i]) ram[i] = 32'h0;
	// read data only in the grant cycle, a misleading value otherwise
	assign mem_rdata = mem_gnt ? ram[mem.addr[10:2]] : ~ram[mem.addr[10:2]];
	always @(posedge mclk) begin
		if (rst || mem_gnt || !mem.req) begin
			mem_gnt <= 1'b0;
			wait_ff <= 2'h0;
		end else if (wait_ff >= {slow, 1'b0}) begin
			mem_gnt <= 1'b1;
		end else begin
			wait_ff <= wait_ff + 2'h1;
		end
		if (mem_gnt && mem.we) begin
			ram[mem.addr[10:2]] <= mem.wdata;
		end
	end
endmodule

// ==== testbench/hbd_engine_tb_top.sv ====
// testbench for hbd_engine: transmit table walk and receive frame tails
// assumes hbd_mem_model as shared memory and the bench as serial side
`timescale 1ns/1ps
module hbd_engine_tb_top import hbd_pkg::*;;
	logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, slow = 0, tx_take = 0, tx_error = 0;
	logic [7:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, mem_rdata, v;
	logic mem_gnt, rx_end_ready;
	hbd_mem_req_t mem;
	hbd_tx_byte_t tx_out;
	hbd_rx_end_t rx_end = '0;
	int bad_count = 0, num_checks = 0;
	logic [9:0] got[$];
	hbd_engine #(.POLL(2)) u_hbd_engine (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem(mem),
		.mem_gnt(mem_gnt), .mem_rdata(mem_rdata), .tx_out(tx_out), .tx_take(tx_take),
		.tx_error(tx_error), .rx_end(rx_end), .rx_end_ready(rx_end_ready));
	hbd_mem_model u_hbd_mem_model (.mclk(mclk), .rst(rst), .slow(slow), .mem(mem),
		.mem_gnt(mem_gnt), .mem_rdata(mem_rdata));
	initial forever #20 mclk = ~mclk;
	// serial side: take each byte one cycle after it appears
	always @(posedge mclk) begin
		tx_take <= tx_out.valid && !tx_take;
		if (tx_out.valid && tx_take) got.push_back({tx_out.data, tx_out.last, tx_out.append_crc_flag});
	end
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask
	task automatic put(logic [31:0] a, logic [31:0] d);
		u_hbd_mem_model.ram[a[10:2]] = d;
	endtask
	task automatic mem_chk(string n, logic [31:0] a, logic [31:0] e);
		check(n, u_hbd_mem_model.ram[a[10:2]], e);
	endtask
	task automatic wait_bytes(int n);
		repeat (3000) if (got.size() < n) @(posedge mclk);
	endtask
	task automatic rx_case(logic [15:0] o, logic [2:0] b, logic [7:0] d, logic [31:0] ta,
		logic [31:0] tw, logic [31:0] st);
		put(32'h180, 32'h1);
		put(ta, 32'h0);
		@(posedge mclk);
		rx_end <= {1'b1, o, b, d};
		repeat (100) begin
			@(negedge mclk);
			if (rx_end_ready) break;
		end
		@(posedge mclk);
		rx_end <= '0;
		repeat (300) if (u_hbd_mem_model.ram[9'h060][0]) @(posedge mclk);
		repeat (20) @(posedge mclk);
		mem_chk("rx status", 32'h180, st);
		mem_chk("rx tail", ta, tw);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		rd(REG_CTRL, v);
		check("ctrl reset", v, 32'h0);
		rd(REG_TX_BASE, v);
		check("base reset", v, 32'h0);
		rd(8'h20, v);
		check("unmapped", v, 32'h0);
		rd(REG_STATUS, v);
		check("state idle", v, 32'h0000_0001);
		// two-entry table; crc bit on a middle buffer must be ignored
		put(32'h100, 32'h0002_0029);
		put(32'h104, 32'h200);
		put(32'h200, 32'ha1b2_c3d4);
		put(32'h108, 32'h0001_0035);
		put(32'h10c, 32'h210);
		put(32'h210, 32'h5e00_0000);
		put(32'h184, 32'h400);
		wr(REG_TX_BASE, 32'h100);
		wr(REG_EVENT_ADDR, 32'h300);
		wr(REG_RX_BASE, 32'h180);
		wr(REG_CTRL, 32'h7);
		wait_bytes(3);
		check("byte0", got[0], {8'ha1, 2'b00});
		check("byte1", got[1], {8'hb2, 2'b00});
		check("byte2", got[2], {8'h5e, 2'b11});
		repeat (60) @(posedge mclk);
		check("no stale send", got.size(), 3);
		mem_chk("bd0 done", 32'h100, 32'h0002_0028);
		mem_chk("bd1 done", 32'h108, 32'h0001_0034);
		mem_chk("event", 32'h300, EVT_VALID | EVT_TX_BUFFER);
		mem_chk("no event", 32'h304, 32'h0);
		rd(REG_TX_PTR, v);
		check("wrap", v, 32'h100);
		slow <= 1'b1;
		// host refills only the released entry
		put(32'h100, 32'h0001_0011);
		wait_bytes(4);
		check("flag only", got[3], {8'ha1, 2'b10});
		repeat (60) @(posedge mclk);
		rd(REG_TX_PTR, v);
		check("advance", v, 32'h108);
		// eight-byte buffer aborted by the serial side after its first byte
		put(32'h10c, 32'h220);
		put(32'h108, 32'h0008_0001);
		wait_bytes(5);
		@(posedge mclk);
		tx_error <= 1'b1;
		@(posedge mclk);
		tx_error <= 1'b0;
		repeat (60) @(posedge mclk);
		mem_chk("abort done", 32'h108, 32'h0008_0000);
		check("abort short", got.size() < 12, 1);
		v = got.size();
		// hdlc mode off: crc control on a last buffer is ignored
		wr(REG_CTRL, 32'h1);
		put(32'h114, 32'h200);
		put(32'h110, 32'h0001_0031);
		wait_bytes(v + 1);
		check("crc outside hdlc", got[v], {8'ha1, 2'b10});
		rx_case(16'd12, 3'd2, 8'hc0, 32'h40c, 32'he000_0000, 32'h000d_0810);
		rx_case(16'd10, 3'd3, 8'ha0, 32'h40c, 32'hb000_0000, 32'h000b_0810);
		rx_case(16'd0, 3'd1, 8'h80, 32'h400, 32'hc000_0000, 32'h0001_0810);
		rx_case(16'd8, 3'd0, 8'h00, 32'h408, 32'h0, 32'h0008_0010);
		report_and_stop();
	end
endmodule
